//--- rtl/qec_pkg.sv
// Package of register offsets, field positions and reset values for the quadrature event counter
package qec_pkg;

    // Register port widths and channel count
    localparam int QEC_ADDR_W = 4;
    localparam int QEC_DATA_W = 16;
    localparam int QEC_NUM_CH = 3;

    // Register offsets, word addresses on the plain register port
    localparam logic [3:0] QEC_ADDR_START = 4'h0;
    localparam logic [3:0] QEC_ADDR_UPDOWN = 4'h1;
    localparam logic [3:0] QEC_ADDR_STATUS = 4'h2;
    localparam logic [3:0] QEC_ADDR_MASK = 4'h3;
    localparam logic [3:0] QEC_ADDR_MODE_BASE = 4'h4;
    localparam logic [3:0] QEC_ADDR_COUNT_BASE = 4'h8;

    // Field positions inside a channel mode register
    localparam int QEC_MODE_FREERUN_BIT = 0;
    localparam int QEC_MODE_QUAD_X4_BIT = 1;

    // Channel indices: slot 0 is channel two, 1 is three, 2 is four
    localparam int QEC_CH_NORMAL_ONLY = 0;
    localparam int QEC_CH_SELECTABLE = 1;
    localparam int QEC_CH_X4_ONLY = 2;

    // Counter limits
    localparam logic [15:0] QEC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] QEC_CNT_MIN = 16'h0000;

    // Reset values
    localparam logic [15:0] QEC_RST_COUNT = 16'h0000;
    localparam logic [2:0] QEC_RST_FLAGS = 3'h0;
    localparam logic [15:0] QEC_RST_RDATA = 16'h0000;

endpackage : qec_pkg

//--- rtl/qec_phase_decoder.sv
// Two-phase pulse decoder: turns synchronised phase levels into up and down steps
`timescale 1ns/1ps

module qec_phase_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synchronised phase levels
    input wire logic phase_a,
    input wire logic phase_b,
    // Processing select, high for multiply-by-4
    input wire logic mode_x4,
    // Step outputs, one-cycle pulses
    output logic step_up,
    output logic step_down
);

    // Previous sampled levels
    logic prev_a_reg;
    logic prev_b_reg;
    // Edge and phase terms
    logic a_edge;
    logic b_edge;
    logic single_edge;
    logic lead_up;

    // Remember last sample of both phases
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_a_reg <= 1'b0;
            prev_b_reg <= 1'b0;
        end else begin
            prev_a_reg <= phase_a;
            prev_b_reg <= phase_b;
        end
    end

    // Both phases moving together is a glitch, ignored in multiply-by-4 mode only
    assign a_edge = phase_a ^ prev_a_reg;
    assign b_edge = phase_b ^ prev_b_reg;
    assign single_edge = a_edge ^ b_edge;
    // Forward sequence 01 11 10 00 gives old first xor new second high
    assign lead_up = prev_a_reg ^ phase_b;

    // Step selection per processing type
    always_comb begin
        if (mode_x4) begin
            step_up = single_edge & lead_up;
            step_down = single_edge & ~lead_up;
        end else begin
            step_up = phase_a & ~prev_a_reg & phase_b;
            step_down = ~phase_a & prev_a_reg & phase_b;
        end
    end

    // Normal steps only on first-input edges with second input high
    AST_NORMAL_GATED: assert property (@(posedge clk) disable iff (rst)
        (!mode_x4 && (step_up || step_down)) |-> (a_edge && phase_b && !b_edge))
        else $error("normal step without first edge while second high");

    // Multiply-by-4 forward rise of first with second high counts up
    AST_X4_UP: assert property (@(posedge clk) disable iff (rst)
        (mode_x4 && phase_a && !prev_a_reg && phase_b && prev_b_reg) |-> (step_up && !step_down))
        else $error("x4 forward edge did not step up");

    // Multiply-by-4 fall of first with second high counts down
    AST_X4_DOWN: assert property (@(posedge clk) disable iff (rst)
        (mode_x4 && !phase_a && prev_a_reg && phase_b && prev_b_reg) |-> (step_down && !step_up))
        else $error("x4 reverse edge did not step down");

endmodule : qec_phase_decoder

//--- rtl/qec_top.sv
// Quadrature event counter for channels two to four with register port and interrupt
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module qec_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Encoder pins, bit 0 is channel two
    input wire logic [2:0] phase_in_first,
    input wire logic [2:0] phase_in_second,
    // Interrupt request, level
    output logic irq
);

    // Address match against a per-channel base
    function automatic logic chan_hit(input logic [3:0] addr, input logic [3:0] base, input int idx);
        logic [3:0] target;
        target = base + idx[3:0];
        return addr == target;
    endfunction : chan_hit

    // Channel count, local copy so array bounds are declared before use
    localparam int QEC_NUM_CH_LOCAL = qec_pkg::QEC_NUM_CH;

    // Pin synchronisers, first stage read only by second
    logic [2:0] first_meta_reg;
    logic [2:0] first_sync_reg;
    logic [2:0] second_meta_reg;
    logic [2:0] second_sync_reg;

    // Software controls
    logic [2:0] count_start_flags_reg; // Run bits per channel
    logic [2:0] updown_control_reg; // Two-phase enable bits
    logic [2:0] reload_or_freerun_sel_reg; // High selects free-run
    logic [2:0] quad_processing_sel_reg; // High selects times four, used for channel three only
    logic [2:0] irq_mask_reg; // Interrupt enables
    logic [2:0] irq_status_reg; // Sticky overflow or underflow
    logic [2:0] irq_status_next;

    // Counter state
    logic [15:0] channel_counter_reg [QEC_NUM_CH_LOCAL];
    logic [15:0] reload_reg [QEC_NUM_CH_LOCAL];
    logic [2:0] seen_event_reg; // First count event after start

    // Output flops
    logic [15:0] rdata_reg;
    logic irq_reg;

    // Per-channel event terms
    logic [2:0] mode_x4;
    logic [2:0] step_up;
    logic [2:0] step_down;
    logic [2:0] cnt_up;
    logic [2:0] cnt_down;
    logic [2:0] overflow;
    logic [2:0] underflow;
    logic [2:0] wr_count;
    logic [2:0] load_both;

    // Two-flop synchronisers on all phase pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_meta_reg <= qec_pkg::QEC_RST_FLAGS;
            first_sync_reg <= qec_pkg::QEC_RST_FLAGS;
            second_meta_reg <= qec_pkg::QEC_RST_FLAGS;
            second_sync_reg <= qec_pkg::QEC_RST_FLAGS;
        end else begin
            first_meta_reg <= phase_in_first;
            first_sync_reg <= first_meta_reg;
            second_meta_reg <= phase_in_second;
            second_sync_reg <= second_meta_reg;
        end
    end

    // Processing type per channel
    always_comb begin
        mode_x4[qec_pkg::QEC_CH_NORMAL_ONLY] = 1'b0;
        mode_x4[qec_pkg::QEC_CH_SELECTABLE] = quad_processing_sel_reg[qec_pkg::QEC_CH_SELECTABLE];
        mode_x4[qec_pkg::QEC_CH_X4_ONLY] = 1'b1;
    end

    // One decoder per channel and its gated events
    genvar g;
    generate
        for (g = 0; g < QEC_NUM_CH_LOCAL; g++) begin : g_chan
            qec_phase_decoder u_dec (
                .clk(clk),
                .rst(rst),
                .phase_a(first_sync_reg[g]),
                .phase_b(second_sync_reg[g]),
                .mode_x4(mode_x4[g]),
                .step_up(step_up[g]),
                .step_down(step_down[g])
            );
            // Only pin-derived steps count, and only while running
            assign cnt_up[g] = step_up[g] & count_start_flags_reg[g] & updown_control_reg[g];
            assign cnt_down[g] = step_down[g] & count_start_flags_reg[g] & updown_control_reg[g];
            assign overflow[g] = cnt_up[g] & (channel_counter_reg[g] == qec_pkg::QEC_CNT_MAX);
            assign underflow[g] = cnt_down[g] & (channel_counter_reg[g] == qec_pkg::QEC_CNT_MIN);
            assign wr_count[g] = reg_wr & chan_hit(reg_addr, qec_pkg::QEC_ADDR_COUNT_BASE, g);
            // Stopped, or started with no event yet: write reaches the counter
            assign load_both[g] = wr_count[g] & (~count_start_flags_reg[g] | ~seen_event_reg[g]);
        end
    endgenerate

    // Run bits and two-phase enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_start_flags_reg <= qec_pkg::QEC_RST_FLAGS;
            updown_control_reg <= qec_pkg::QEC_RST_FLAGS;
        end else begin
            if (reg_wr && reg_addr == qec_pkg::QEC_ADDR_START) begin
                count_start_flags_reg <= reg_wdata[2:0];
            end
            // Enable must be set by software before counting
            if (reg_wr && reg_addr == qec_pkg::QEC_ADDR_UPDOWN) begin
                updown_control_reg <= reg_wdata[2:0];
            end
        end
    end

    // Channel mode registers: reload type and processing select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reload_or_freerun_sel_reg <= qec_pkg::QEC_RST_FLAGS;
            quad_processing_sel_reg <= qec_pkg::QEC_RST_FLAGS;
        end else begin
            for (int i = 0; i < QEC_NUM_CH_LOCAL; i++) begin
                if (reg_wr && chan_hit(reg_addr, qec_pkg::QEC_ADDR_MODE_BASE, i)) begin
                    reload_or_freerun_sel_reg[i] <= reg_wdata[qec_pkg::QEC_MODE_FREERUN_BIT];
                    quad_processing_sel_reg[i] <= reg_wdata[qec_pkg::QEC_MODE_QUAD_X4_BIT];
                end
            end
        end
    end

    // Reload registers take every counter write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < QEC_NUM_CH_LOCAL; i++) begin
                reload_reg[i] <= qec_pkg::QEC_RST_COUNT;
            end
        end else begin
            for (int i = 0; i < QEC_NUM_CH_LOCAL; i++) begin
                if (wr_count[i]) begin
                    reload_reg[i] <= reg_wdata;
                end
            end
        end
    end

    // First-event tracker, cleared whenever the channel is stopped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_event_reg <= qec_pkg::QEC_RST_FLAGS;
        end else begin
            for (int i = 0; i < QEC_NUM_CH_LOCAL; i++) begin
                if (!count_start_flags_reg[i]) begin
                    seen_event_reg[i] <= 1'b0;
                end else if ((cnt_up[i] || cnt_down[i]) && !load_both[i]) begin
                    seen_event_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Counters; a write that loads the counter beats a same-cycle step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < QEC_NUM_CH_LOCAL; i++) begin
                channel_counter_reg[i] <= qec_pkg::QEC_RST_COUNT;
            end
        end else begin
            for (int i = 0; i < QEC_NUM_CH_LOCAL; i++) begin
                if (load_both[i]) begin
                    channel_counter_reg[i] <= reg_wdata;
                end else if ((overflow[i] || underflow[i]) && !reload_or_freerun_sel_reg[i]) begin
                    channel_counter_reg[i] <= reload_reg[i];
                end else if (cnt_up[i]) begin
                    // Free-run wraps naturally through all ones
                    channel_counter_reg[i] <= channel_counter_reg[i] + 16'h0001;
                end else if (cnt_down[i]) begin
                    channel_counter_reg[i] <= channel_counter_reg[i] - 16'h0001;
                end
                // Stopped channels fall through and hold
            end
        end
    end

    // Sticky status: a set in the clearing cycle survives
    always_comb begin
        irq_status_next = irq_status_reg;
        if (reg_wr && reg_addr == qec_pkg::QEC_ADDR_STATUS) begin
            irq_status_next = irq_status_next & ~reg_wdata[2:0];
        end
        irq_status_next = irq_status_next | overflow | underflow;
    end

    // Status, mask and interrupt output flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status_reg <= qec_pkg::QEC_RST_FLAGS;
            irq_mask_reg <= qec_pkg::QEC_RST_FLAGS;
            irq_reg <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            if (reg_wr && reg_addr == qec_pkg::QEC_ADDR_MASK) begin
                irq_mask_reg <= reg_wdata[2:0];
            end
            // Registered output lags status by one cycle
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Read data, valid the cycle after the read strobe only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= qec_pkg::QEC_RST_RDATA;
        end else if (reg_rd) begin
            rdata_reg <= qec_pkg::QEC_RST_RDATA;
            unique case (reg_addr)
                qec_pkg::QEC_ADDR_START: rdata_reg <= {13'h0000, count_start_flags_reg};
                qec_pkg::QEC_ADDR_UPDOWN: rdata_reg <= {13'h0000, updown_control_reg};
                qec_pkg::QEC_ADDR_STATUS: rdata_reg <= {13'h0000, irq_status_reg};
                qec_pkg::QEC_ADDR_MASK: rdata_reg <= {13'h0000, irq_mask_reg};
                4'h4, 4'h5, 4'h6: begin
                    rdata_reg <= {14'h0000, quad_processing_sel_reg[reg_addr[1:0]],
                        reload_or_freerun_sel_reg[reg_addr[1:0]]};
                end
                4'h8, 4'h9, 4'hA: begin
                    rdata_reg <= channel_counter_reg[reg_addr[1:0]];
                end
                default: begin
                    // Unmapped addresses read as zero
                    rdata_reg <= qec_pkg::QEC_RST_RDATA;
                end
            endcase
        end else begin
            rdata_reg <= qec_pkg::QEC_RST_RDATA;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = rdata_reg;
    assign irq = irq_reg;

    // Checks per channel
    generate
        for (g = 0; g < QEC_NUM_CH_LOCAL; g++) begin : g_chk
            AST_RELOAD_ON_WRAP: assert property (@(posedge clk) disable iff (rst)
                ((overflow[g] || underflow[g]) && !reload_or_freerun_sel_reg[g] && !load_both[g])
                |=> channel_counter_reg[g] == $past(reload_reg[g]))
                else $error("reload type did not reload on wrap");

            AST_FREERUN_WRAP: assert property (@(posedge clk) disable iff (rst)
                (overflow[g] && reload_or_freerun_sel_reg[g] && !load_both[g])
                |=> channel_counter_reg[g] == qec_pkg::QEC_CNT_MIN)
                else $error("free-run overflow did not wrap to zero");

            AST_UP_STEP: assert property (@(posedge clk) disable iff (rst)
                (cnt_up[g] && !overflow[g] && !load_both[g])
                |=> channel_counter_reg[g] == $past(channel_counter_reg[g]) + 16'h0001)
                else $error("up step did not add one");

            AST_DOWN_STEP: assert property (@(posedge clk) disable iff (rst)
                (cnt_down[g] && !underflow[g] && !load_both[g])
                |=> channel_counter_reg[g] == $past(channel_counter_reg[g]) - 16'h0001)
                else $error("down step did not subtract one");

            AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (rst)
                (!count_start_flags_reg[g] && !wr_count[g]) |=> $stable(channel_counter_reg[g]))
                else $error("stopped counter moved");

            AST_WRITE_BOTH: assert property (@(posedge clk) disable iff (rst)
                (wr_count[g] && !count_start_flags_reg[g])
                |=> (channel_counter_reg[g] == $past(reg_wdata) && reload_reg[g] == $past(reg_wdata)))
                else $error("stopped write missed counter or reload");

            AST_WRITE_RELOAD_ONLY: assert property (@(posedge clk) disable iff (rst)
                (wr_count[g] && count_start_flags_reg[g] && seen_event_reg[g] && !cnt_up[g] && !cnt_down[g])
                |=> ($stable(channel_counter_reg[g]) && reload_reg[g] == $past(reg_wdata)))
                else $error("running write touched counter");

            AST_WRAP_TO_IRQ: assert property (@(posedge clk) disable iff (rst)
                (overflow[g] || underflow[g]) ##0 irq_mask_reg[g] ##1 irq_mask_reg[g] |=> irq)
                else $error("wrap did not raise interrupt");

            AST_FIRST_EVENT: assert property (@(posedge clk) disable iff (rst)
                (count_start_flags_reg[g] && (cnt_up[g] || cnt_down[g]) && !load_both[g]) |=> seen_event_reg[g])
                else $error("first count event not recorded");
        end
    endgenerate

    // Run bit write takes effect on the next edge
    AST_START_BIT: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == qec_pkg::QEC_ADDR_START) |=> count_start_flags_reg == $past(reg_wdata[2:0]))
        else $error("run bits not updated by write");

    // Counter read returns the count seen at the strobe
    AST_COUNT_READ: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == qec_pkg::QEC_ADDR_COUNT_BASE)
        |=> reg_rdata == $past(channel_counter_reg[0]))
        else $error("counter read returned wrong value");

    // Channel two never uses times-four, channel four always does
    AST_FIXED_MODES: assert property (@(posedge clk) disable iff (rst)
        !mode_x4[qec_pkg::QEC_CH_NORMAL_ONLY] && mode_x4[qec_pkg::QEC_CH_X4_ONLY])
        else $error("fixed processing type violated");

    // Without two-phase enable no step counts
    AST_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (rst)
        (updown_control_reg == 3'h0) |-> (cnt_up == 3'h0 && cnt_down == 3'h0))
        else $error("count without two-phase enable");

    // Nothing unmasked pending means the request drops next cycle
    AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (rst)
        ((irq_status_reg & irq_mask_reg) == 3'h0) |=> !irq)
        else $error("interrupt high with nothing unmasked pending");

endmodule : qec_top

//--- tb/qec_encoder_model.sv
// Behavioural two-phase encoder driving the phase pins of all three channels
`timescale 1ns/1ps

module qec_encoder_model (
    // Clock
    input wire logic clk,
    // Phase pins toward the counter, bit 0 is channel two
    output logic [2:0] phase_in_first,
    output logic [2:0] phase_in_second
);
    // Position in the four-state cycle per channel, 3 means both pins low
    logic [1:0] pos [3];

    // Both pins low at time zero so no step appears at reset release
    initial begin
        pos[0] = 2'h3;
        pos[1] = 2'h3;
        pos[2] = 2'h3;
        phase_in_first = 3'h0;
        phase_in_second = 3'h0;
    end

    // One quarter step; levels held at least five cycles, longer than the two that sync needs
    task step(input int ch, input logic fwd);
        logic [1:0] p;
        begin
            p = fwd ? pos[ch] + 2'h1 : pos[ch] - 2'h1;
            pos[ch] = p;
            @(posedge clk);
            // Only one pin changes per step, so the phase relation is always clean
            phase_in_first[ch] <= (p == 2'h1) || (p == 2'h2);
            phase_in_second[ch] <= (p == 2'h0) || (p == 2'h1);
            repeat (4) @(posedge clk);
        end
    endtask : step
endmodule : qec_encoder_model

//--- tb/testbench.sv
// Self-checking bench for the quadrature event counter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench;
    // Clock, reset and register port
    logic clk;
    logic rst;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    // Encoder pins and interrupt
    logic [2:0] phase_in_first;
    logic [2:0] phase_in_second;
    logic irq;
    // Tallies
    int failures;
    int n_checks;
    logic [15:0] d;
    // Counter addresses of channels two to four
    localparam logic [3:0] A_CNT2 = qec_pkg::QEC_ADDR_COUNT_BASE;
    localparam logic [3:0] A_CNT3 = qec_pkg::QEC_ADDR_COUNT_BASE + 4'h1;
    localparam logic [3:0] A_CNT4 = qec_pkg::QEC_ADDR_COUNT_BASE + 4'h2;

    // Device under test
    qec_top u_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_in_first(phase_in_first),
        .phase_in_second(phase_in_second), .irq(irq)
    );

    // Encoder on the far side
    qec_encoder_model u_enc (
        .clk(clk), .phase_in_first(phase_in_first), .phase_in_second(phase_in_second)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // One-cycle write strobe
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data sampled in the single cycle it stands
    task rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Several quarter steps in one direction
    task steps(input int ch, input logic fwd, input int n);
        repeat (n) u_enc.step(ch, fwd);
    endtask : steps

    // Reset values and the unmapped hole
    task t_reset;
        rd(A_CNT3, d); `CHK("cnt3 reset", 16'h0000, d)
        rd(qec_pkg::QEC_ADDR_STATUS, d); `CHK("status reset", 16'h0000, d)
        rd(4'hF, d); `CHK("unmapped", 16'h0000, d)
        `CHK("irq reset", 1'b0, irq)
    endtask : t_reset

    // Channel two: normal only, start gating and stop hold
    task t_normal;
        wr(qec_pkg::QEC_ADDR_UPDOWN, 16'h0007);
        wr(qec_pkg::QEC_ADDR_MODE_BASE, 16'h0002);
        wr(A_CNT2, 16'h0010);
        steps(0, 1'b1, 4);
        rd(A_CNT2, d); `CHK("cnt2 not started", 16'h0010, d)
        wr(qec_pkg::QEC_ADDR_START, 16'h0007);
        steps(0, 1'b1, 4);
        rd(A_CNT2, d); `CHK("cnt2 up", 16'h0011, d)
        steps(0, 1'b0, 8);
        rd(A_CNT2, d); `CHK("cnt2 down", 16'h000F, d)
        wr(qec_pkg::QEC_ADDR_START, 16'h0006);
        steps(0, 1'b1, 4);
        rd(A_CNT2, d); `CHK("cnt2 held", 16'h000F, d)
    endtask : t_normal

    // Channel three selectable, channel four fixed to times four
    task t_x4;
        steps(1, 1'b1, 4);
        rd(A_CNT3, d); `CHK("cnt3 normal", 16'h0001, d)
        wr(qec_pkg::QEC_ADDR_MODE_BASE + 4'h1, 16'h0002);
        steps(1, 1'b1, 3);
        rd(A_CNT3, d); `CHK("cnt3 x4", 16'h0004, d)
        steps(2, 1'b1, 4);
        rd(A_CNT4, d); `CHK("cnt4 x4 up", 16'h0004, d)
        steps(2, 1'b0, 6);
        rd(A_CNT4, d); `CHK("cnt4 x4 down", 16'h0000, d)
        rd(qec_pkg::QEC_ADDR_STATUS, d); `CHK("cnt4 reload udf", 16'h0004, d)
    endtask : t_x4

    // Channel four reload type: overflow count, write timing, interrupt
    task t_reload;
        wr(qec_pkg::QEC_ADDR_START, 16'h0003);
        wr(qec_pkg::QEC_ADDR_STATUS, 16'h0007);
        wr(qec_pkg::QEC_ADDR_START, 16'h0007);
        wr(A_CNT4, 16'hFFFD);
        rd(A_CNT4, d); `CHK("write before event", 16'hFFFD, d)
        wr(qec_pkg::QEC_ADDR_MASK, 16'h0004);
        steps(2, 1'b1, 1);
        wr(A_CNT4, 16'h1234);
        rd(A_CNT4, d); `CHK("write after event", 16'hFFFE, d)
        steps(2, 1'b1, 1);
        rd(qec_pkg::QEC_ADDR_STATUS, d); `CHK("no early ovf", 16'h0000, d)
        steps(2, 1'b1, 1);
        rd(A_CNT4, d); `CHK("reloaded", 16'h1234, d)
        rd(qec_pkg::QEC_ADDR_STATUS, d); `CHK("ovf status", 16'h0004, d)
        `CHK("irq up", 1'b1, irq)
        wr(qec_pkg::QEC_ADDR_MASK, 16'h0000);
        @(posedge clk);
        #1 `CHK("irq masked", 1'b0, irq)
        wr(qec_pkg::QEC_ADDR_MASK, 16'h0004);
        wr(qec_pkg::QEC_ADDR_STATUS, 16'h0004);
        rd(qec_pkg::QEC_ADDR_STATUS, d); `CHK("status cleared", 16'h0000, d)
        `CHK("irq cleared", 1'b0, irq)
    endtask : t_reload

    // Channel four free-run: underflow after n plus one, wrap without reload
    task t_freerun;
        wr(qec_pkg::QEC_ADDR_START, 16'h0003);
        wr(qec_pkg::QEC_ADDR_MODE_BASE + 4'h2, 16'h0001);
        wr(A_CNT4, 16'h0001);
        wr(qec_pkg::QEC_ADDR_START, 16'h0007);
        steps(2, 1'b0, 1);
        rd(qec_pkg::QEC_ADDR_STATUS, d); `CHK("no early udf", 16'h0000, d)
        steps(2, 1'b0, 1);
        rd(A_CNT4, d); `CHK("free wrap", 16'hFFFF, d)
        rd(qec_pkg::QEC_ADDR_STATUS, d); `CHK("udf status", 16'h0004, d)
        wr(qec_pkg::QEC_ADDR_UPDOWN, 16'h0003);
        steps(2, 1'b0, 1);
        rd(A_CNT4, d); `CHK("no enable held", 16'hFFFF, d)
    endtask : t_freerun

    // Verdict, reached from the main sequence or the watchdog
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence with reset held six cycles
    initial begin
        failures = 0;
        n_checks = 0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_normal();
        t_x4();
        t_reload();
        t_freerun();
        tally_and_finish();
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
endmodule : testbench
